// ### hw/mptc_device.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Enable divider
// ------------------------------------------------------------
module mptc_tick #(
    parameter int unsigned DIV = 1
) (
    input wire logic sys_clk,
    input wire logic srst,
    output logic tick
);
    logic [mptc_pkg::TICK_CNT_W-1:0] cnt;
    logic wrap;

    assign wrap = (cnt == mptc_pkg::TICK_CNT_W'(DIV - 1));

    always_ff @(posedge sys_clk)
    begin
        cnt <= (srst || wrap) ? '0 : cnt + 1'b1;
        tick <= !srst && wrap;
    end
endmodule

// ------------------------------------------------------------
// Domain-crossing FIFO: write and read on separate enables
// ------------------------------------------------------------
module mptc_xfifo #(
    parameter int unsigned W = 8,
    parameter int unsigned DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    input wire logic rd_en,
    output logic [W-1:0] rd_data,
    output logic full,
    output logic empty
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    // Wrap bit on each pointer; DEPTH must be a power of two
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    assign full = (wr_ptr == {~rd_ptr[AW], rd_ptr[AW-1:0]});
    assign empty = (wr_ptr == rd_ptr);
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;
    assign rd_data = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge sys_clk)
    begin
        if (do_wr)
        begin
            mem[wr_ptr[AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(do_wr);
            rd_ptr <= rd_ptr + (AW+1)'(do_rd);
        end
    end
endmodule

// ------------------------------------------------------------
// Device end: MAC timestamp path
// ------------------------------------------------------------
module mptc_device #(
    parameter int unsigned DATA_W = mptc_pkg::DATA_W,
    parameter int unsigned TX_DIV = mptc_pkg::TX_FIFO_DIV,
    parameter int unsigned RX_DIV = mptc_pkg::RX_FIFO_DIV,
    parameter int unsigned CORE_DIV = mptc_pkg::CORE_DIV,
    parameter int unsigned LINE_DIV = mptc_pkg::LINE_DIV,
    parameter int unsigned TX_DEPTH = mptc_pkg::TX_FIFO_DEPTH,
    parameter int unsigned RX_DEPTH = mptc_pkg::RX_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic srst,
    mptc_link_if.dev link,
    output logic line_tx_valid,
    output logic line_tx_sop,
    output logic line_tx_eop,
    output logic [DATA_W-1:0] line_tx_data,
    input wire logic line_rx_valid,
    input wire logic line_rx_sop,
    input wire logic line_rx_eop,
    input wire logic [DATA_W-1:0] line_rx_data,
    input wire logic sw_capture_read,
    output logic [mptc_pkg::CAPTURE_W-1:0] tx_capture_value,
    output logic capture_ready_flag
);
    localparam int unsigned TXW = DATA_W + 3 + mptc_pkg::TAG_W;
    localparam int unsigned RXW = DATA_W + 2 + mptc_pkg::TS_FIELD_W;

    logic tx_en, rx_en, core_en, line_en;
    logic [mptc_pkg::CAPTURE_W-1:0] ts_count;
    logic tx_full, tx_empty, rx_empty, tx_pop, rx_pop, tx_push;
    logic [TXW-1:0] tx_in, tx_out;
    logic [RXW-1:0] rx_in, rx_out;
    logic [DATA_W-1:0] pop_data;
    logic pop_sop, pop_eop, pop_flag, capture_set;
    logic [mptc_pkg::TAG_W-1:0] pop_tag;

    // ------------------------------------------------------------
    // Domain enables
    // ------------------------------------------------------------
    // One divider per domain, no ratio assumed between them
    mptc_tick #(.DIV(TX_DIV)) u_tick_tx (.sys_clk(sys_clk), .srst(srst), .tick(tx_en));
    mptc_tick #(.DIV(RX_DIV)) u_tick_rx (.sys_clk(sys_clk), .srst(srst), .tick(rx_en));
    mptc_tick #(.DIV(CORE_DIV)) u_tick_core (.sys_clk(sys_clk), .srst(srst), .tick(core_en));
    mptc_tick #(.DIV(LINE_DIV)) u_tick_line (.sys_clk(sys_clk), .srst(srst), .tick(line_en));

    assign link.fabric_tx_fifo_clock = tx_en;
    assign link.fabric_rx_fifo_clock = rx_en;

    // Free-running nanosecond time base
    always_ff @(posedge sys_clk)
    begin
        ts_count <= srst ? mptc_pkg::TS_COUNT_RESET : ts_count + mptc_pkg::TS_STEP_NS;
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    // Fabric side writes only on its own enable
    assign tx_push = tx_en && link.tx_valid && link.tx_ready;
    assign tx_in = {link.tx_data, link.tx_sop, link.tx_eop, link.tx_frame_flag, link.tx_frame_tag};
    assign tx_pop = core_en && !tx_empty;
    assign {pop_data, pop_sop, pop_eop, pop_flag, pop_tag} = tx_out;

    mptc_xfifo #(.W(TXW), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .wr_en(tx_push),
        .wr_data(tx_in),
        .rd_en(tx_pop),
        .rd_data(tx_out),
        .full(tx_full),
        .empty(tx_empty)
    );

    // Registered ready lags a cycle; safe since write enables are two apart
    always_ff @(posedge sys_clk)
    begin
        link.tx_ready <= !srst && !tx_full;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            line_tx_valid <= 1'b0;
            line_tx_sop <= 1'b0;
            line_tx_eop <= 1'b0;
            line_tx_data <= '0;
        end
        else
        begin
            line_tx_valid <= tx_pop;
            line_tx_sop <= tx_pop && pop_sop;
            line_tx_eop <= tx_pop && pop_eop;
            if (tx_pop)
            begin
                line_tx_data <= pop_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit capture
    // ------------------------------------------------------------
    // Tag is carried through; the capture does not depend on it
    assign capture_set = tx_pop && pop_sop && (pop_flag == mptc_pkg::FRAME_FLAG_ON);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            tx_capture_value <= mptc_pkg::CAPTURE_RESET;
        end
        else if (capture_set)
        begin
            tx_capture_value <= ts_count[mptc_pkg::CAPTURE_W-1:0];
        end
    end

    // A capture in the read cycle wins over the clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            capture_ready_flag <= 1'b0;
        end
        else
        begin
            capture_ready_flag <= capture_set || (capture_ready_flag && !sw_capture_read);
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    // Stamp taken as the packet enters; only 30 bits reach the fabric
    assign rx_in = {line_rx_data, line_rx_sop, line_rx_eop, ts_count[mptc_pkg::TS_FIELD_W-1:0]};
    assign rx_pop = rx_en && !rx_empty;

    // Overflow drops the word: the fabric rate must keep up
    mptc_xfifo #(.W(RXW), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .wr_en(line_en && line_rx_valid),
        .wr_data(rx_in),
        .rd_en(rx_pop),
        .rd_data(rx_out),
        .full(),
        .empty(rx_empty)
    );

    // Drained only on the fabric receive enable
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            link.rx_valid <= 1'b0;
            link.packet_begin_pulse <= 1'b0;
            link.rx_eop <= 1'b0;
            link.rx_data <= '0;
            link.rx_ts <= '0;
        end
        else
        begin
            link.rx_valid <= rx_pop;
            link.packet_begin_pulse <= rx_pop && rx_out[mptc_pkg::TS_FIELD_W+1];
            link.rx_eop <= rx_pop && rx_out[mptc_pkg::TS_FIELD_W];
            if (rx_pop)
            begin
                link.rx_data <= rx_out[RXW-1 -: DATA_W];
                link.rx_ts <= rx_out[mptc_pkg::TS_FIELD_W-1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ### inc/mptc_pkg.sv
`default_nettype none
package mptc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W = 64;
    localparam int unsigned TS_FIELD_W = 30;
    localparam int unsigned CAPTURE_W = 32;
    localparam int unsigned TAG_W = 16;
    localparam int unsigned TAG_1588_BIT = 15;
    localparam logic TAG_1588_SELECT = 1'b0;
    localparam logic FRAME_FLAG_ON = 1'b1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CAPTURE_W-1:0] CAPTURE_RESET = 32'h0000_0000;
    localparam logic [CAPTURE_W-1:0] TS_COUNT_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam logic [CAPTURE_W-1:0] TS_STEP_NS = CAPTURE_W'(CLK_PERIOD_NS);

    // Divider defaults; every domain rate is an enable pulse from sys_clk
    localparam int unsigned TX_FIFO_DIV = 2;
    localparam int unsigned RX_FIFO_DIV = 2;
    localparam int unsigned CORE_DIV = 1;
    localparam int unsigned LINE_DIV = 3;
    localparam int unsigned TX_FIFO_DEPTH = 8;
    localparam int unsigned RX_FIFO_DEPTH = 8;
    localparam int unsigned TICK_CNT_W = 16;
endpackage
`default_nettype wire

// ### inc/mptc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mptc_link_if #(
    parameter int unsigned DATA_W = mptc_pkg::DATA_W
);
    // ------------------------------------------------------------
    // Domain enables, made by the device end
    // ------------------------------------------------------------
    logic fabric_tx_fifo_clock;
    logic fabric_rx_fifo_clock;

    // ------------------------------------------------------------
    // Transmit stream, fabric to device
    // ------------------------------------------------------------
    logic tx_valid;
    logic tx_ready;
    logic tx_sop;
    logic tx_eop;
    logic [DATA_W-1:0] tx_data;
    logic tx_frame_flag;
    logic [mptc_pkg::TAG_W-1:0] tx_frame_tag;

    // ------------------------------------------------------------
    // Receive stream, device to fabric
    // ------------------------------------------------------------
    logic rx_valid;
    logic packet_begin_pulse;
    logic rx_eop;
    logic [DATA_W-1:0] rx_data;
    logic [mptc_pkg::TS_FIELD_W-1:0] rx_ts;

    modport dev (
        output fabric_tx_fifo_clock,
        output fabric_rx_fifo_clock,
        input tx_valid,
        output tx_ready,
        input tx_sop,
        input tx_eop,
        input tx_data,
        input tx_frame_flag,
        input tx_frame_tag,
        output rx_valid,
        output packet_begin_pulse,
        output rx_eop,
        output rx_data,
        output rx_ts
    );

    modport fab (
        input fabric_tx_fifo_clock,
        input fabric_rx_fifo_clock,
        output tx_valid,
        input tx_ready,
        output tx_sop,
        output tx_eop,
        output tx_data,
        output tx_frame_flag,
        output tx_frame_tag,
        input rx_valid,
        input packet_begin_pulse,
        input rx_eop,
        input rx_data,
        input rx_ts
    );
endinterface
`default_nettype wire

// ### hw/mptc_fabric.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Fabric end: user logic at the access point
// ------------------------------------------------------------
module mptc_fabric #(
    parameter int unsigned DATA_W = mptc_pkg::DATA_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    mptc_link_if.fab link,
    input wire logic usr_tx_valid,
    input wire logic usr_tx_sop,
    input wire logic usr_tx_eop,
    input wire logic [DATA_W-1:0] usr_tx_data,
    input wire logic usr_tx_event,
    input wire logic [mptc_pkg::TAG_W-1:0] usr_tx_tag,
    output logic usr_tx_accept,
    output logic usr_rx_valid,
    output logic usr_rx_sop,
    output logic usr_rx_eop,
    output logic [DATA_W-1:0] usr_rx_data,
    output logic [mptc_pkg::TS_FIELD_W-1:0] usr_rx_ts
);
    logic advance;
    logic load;
    logic [mptc_pkg::TAG_W-1:0] next_tag;

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    // Holding stage moves only on the transmit enable
    assign advance = link.fabric_tx_fifo_clock && (!link.tx_valid || link.tx_ready);
    assign load = advance && usr_tx_valid;

    always_comb
    begin
        next_tag = usr_tx_tag;
        if (usr_tx_event)
        begin
            next_tag[mptc_pkg::TAG_1588_BIT] = mptc_pkg::TAG_1588_SELECT;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            link.tx_valid <= 1'b0;
            link.tx_sop <= 1'b0;
            link.tx_eop <= 1'b0;
            link.tx_data <= '0;
            link.tx_frame_flag <= 1'b0;
            link.tx_frame_tag <= '0;
        end
        else if (advance)
        begin
            link.tx_valid <= usr_tx_valid;
            link.tx_sop <= usr_tx_sop;
            link.tx_eop <= usr_tx_eop;
            link.tx_data <= usr_tx_data;
            // Flag only on event frames, on their first word
            link.tx_frame_flag <= usr_tx_valid && usr_tx_sop && usr_tx_event;
            link.tx_frame_tag <= next_tag;
        end
    end

    // User holds its word until this pulse
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            usr_tx_accept <= 1'b0;
        end
        else
        begin
            usr_tx_accept <= load;
        end
    end

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            usr_rx_valid <= 1'b0;
            usr_rx_sop <= 1'b0;
            usr_rx_eop <= 1'b0;
            usr_rx_data <= '0;
        end
        else
        begin
            usr_rx_valid <= link.rx_valid;
            usr_rx_sop <= link.rx_valid && link.packet_begin_pulse;
            usr_rx_eop <= link.rx_valid && link.rx_eop;
            if (link.rx_valid)
            begin
                usr_rx_data <= link.rx_data;
            end
        end
    end

    // Stamp kept for the whole packet, renewed only at its start
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            usr_rx_ts <= '0;
        end
        else if (link.rx_valid && link.packet_begin_pulse)
        begin
            usr_rx_ts <= link.rx_ts;
        end
    end
endmodule
`default_nettype wire

// ### dv/mptc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mptc_assertions #(
    parameter int unsigned DATA_W = 64
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic fabric_tx_fifo_clock,
    input wire logic fabric_rx_fifo_clock,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_sop,
    input wire logic [DATA_W-1:0] tx_data,
    input wire logic tx_frame_flag,
    input wire logic [mptc_pkg::TAG_W-1:0] tx_frame_tag,
    input wire logic rx_valid,
    input wire logic packet_begin_pulse,
    input wire logic rx_eop,
    input wire logic [DATA_W-1:0] rx_data,
    input wire logic [mptc_pkg::TS_FIELD_W-1:0] rx_ts
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    a_begin_with_valid: assert property (packet_begin_pulse |-> rx_valid) else $error("begin pulse alone");
    a_eop_with_valid: assert property (rx_eop |-> rx_valid) else $error("rx end pulse alone");
    // Stamp must not drift between words, the fabric latches it late
    a_rx_stamp_held: assert property (!rx_valid |-> $stable(rx_ts) && $stable(rx_data)) else $error("rx moved idle");
    a_rx_after_enable: assert property (rx_valid |-> $past(fabric_rx_fifo_clock)) else $error("rx off enable");
    a_rx_word_gap: assert property (rx_valid |=> !rx_valid) else $error("rx words back to back");
    a_rx_enable_rate: assert property (fabric_rx_fifo_clock |=> !fabric_rx_fifo_clock ##1 $rose(fabric_rx_fifo_clock)) else $error("rx enable rate");

    // ------------------------------------------------------------
    // Transmit side
    // ------------------------------------------------------------
    a_tx_enable_rate: assert property (fabric_tx_fifo_clock |=> !fabric_tx_fifo_clock ##1 fabric_tx_fifo_clock) else $error("tx enable rate");
    a_tx_word_held: assert property (tx_valid && !(fabric_tx_fifo_clock && tx_ready) |=> tx_valid && $stable(tx_data) && $stable(tx_sop)) else $error("tx word dropped");
    a_flag_on_sop: assert property (tx_valid && tx_frame_flag |-> tx_sop) else $error("flag off first word");
    a_event_tag_bit: assert property (tx_valid && tx_frame_flag |-> tx_frame_tag[mptc_pkg::TAG_1588_BIT] == mptc_pkg::TAG_1588_SELECT) else $error("event tag bit");

    c_event_taken: cover property (tx_valid && tx_frame_flag && fabric_tx_fifo_clock && tx_ready);
    c_rx_begin: cover property (packet_begin_pulse);
    c_rx_end: cover property (rx_valid && rx_eop);
endmodule
`default_nettype wire

// ### dv/mptc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mptc_tb;
    logic sys_clk;
    logic srst;
    logic usr_tx_valid, usr_tx_sop, usr_tx_eop, usr_tx_event, usr_tx_accept;
    logic [63:0] usr_tx_data, usr_rx_data, line_tx_data, line_rx_data;
    logic [15:0] usr_tx_tag;
    logic usr_rx_valid, usr_rx_sop, usr_rx_eop;
    logic [29:0] usr_rx_ts;
    logic line_tx_valid, line_tx_sop, line_tx_eop, line_rx_valid, line_rx_sop, line_rx_eop;
    logic sw_capture_read, capture_ready_flag;
    logic [31:0] tx_capture_value;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [63:0] txq[$];
    int sopq[$];
    logic [63:0] rxd[$];
    logic [29:0] rxt[$];
    logic rxs[$];
    logic rxe[$];
    logic [29:0] lts[$];
    int eopn = 0;

    mptc_link_if u_mptc_link_if ();
    mptc_device u_mptc_device (.sys_clk(sys_clk), .srst(srst), .link(u_mptc_link_if),
        .line_tx_valid(line_tx_valid), .line_tx_sop(line_tx_sop), .line_tx_eop(line_tx_eop),
        .line_tx_data(line_tx_data), .line_rx_valid(line_rx_valid), .line_rx_sop(line_rx_sop),
        .line_rx_eop(line_rx_eop), .line_rx_data(line_rx_data), .sw_capture_read(sw_capture_read),
        .tx_capture_value(tx_capture_value), .capture_ready_flag(capture_ready_flag));
    mptc_fabric u_mptc_fabric (.sys_clk(sys_clk), .srst(srst), .link(u_mptc_link_if),
        .usr_tx_valid(usr_tx_valid), .usr_tx_sop(usr_tx_sop), .usr_tx_eop(usr_tx_eop),
        .usr_tx_data(usr_tx_data), .usr_tx_event(usr_tx_event), .usr_tx_tag(usr_tx_tag),
        .usr_tx_accept(usr_tx_accept), .usr_rx_valid(usr_rx_valid), .usr_rx_sop(usr_rx_sop),
        .usr_rx_eop(usr_rx_eop), .usr_rx_data(usr_rx_data), .usr_rx_ts(usr_rx_ts));
    mptc_assertions u_mptc_assertions (.sys_clk(sys_clk), .srst(srst),
        .fabric_tx_fifo_clock(u_mptc_link_if.fabric_tx_fifo_clock),
        .fabric_rx_fifo_clock(u_mptc_link_if.fabric_rx_fifo_clock),
        .tx_valid(u_mptc_link_if.tx_valid), .tx_ready(u_mptc_link_if.tx_ready), .tx_sop(u_mptc_link_if.tx_sop),
        .tx_data(u_mptc_link_if.tx_data), .tx_frame_flag(u_mptc_link_if.tx_frame_flag),
        .tx_frame_tag(u_mptc_link_if.tx_frame_tag), .rx_valid(u_mptc_link_if.rx_valid),
        .packet_begin_pulse(u_mptc_link_if.packet_begin_pulse), .rx_eop(u_mptc_link_if.rx_eop),
        .rx_data(u_mptc_link_if.rx_data), .rx_ts(u_mptc_link_if.rx_ts));

    // ------------------------------------------------------------
    // Clock and monitors
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (line_tx_valid === 1'b1) txq.push_back(line_tx_data);
        if (line_tx_sop === 1'b1) sopq.push_back(cyc);
        if (line_tx_eop === 1'b1) eopn++;
        if (u_mptc_link_if.rx_valid === 1'b1) lts.push_back(u_mptc_link_if.rx_ts);
        if (usr_rx_valid === 1'b1)
        begin
            rxe.push_back(usr_rx_eop);
            rxd.push_back(usr_rx_data);
            rxt.push_back(usr_rx_ts);
            rxs.push_back(usr_rx_sop);
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Each word is held until the fabric end accepts it
    task automatic send_frame(input int n, input logic ev, input logic [15:0] tag, input logic [63:0] base);
        int k;
        for (int i = 0; i < n; i++)
        begin
            usr_tx_valid = 1'b1;
            usr_tx_sop = (i == 0);
            usr_tx_eop = (i == n - 1);
            usr_tx_data = base + 64'(i);
            usr_tx_event = ev;
            usr_tx_tag = tag;
            k = 0;
            do
            begin
                tick(1);
                k++;
            end while (usr_tx_accept !== 1'b1 && k < 40);
            chk_bit("tx accept", 1'b1, usr_tx_accept);
        end
        usr_tx_valid = 1'b0;
        usr_tx_data = ~usr_tx_data;
    endtask

    task automatic wait_for(input int n, input bit rx);
        int k;
        k = 0;
        while ((rx ? rxd.size() : txq.size()) < n && k < 200)
        begin
            tick(1);
            k++;
        end
        tick(3);
    endtask

    // Three cycles always span exactly one line enable
    task automatic line_word(input logic sop, input logic eop, input logic [63:0] d);
        line_rx_valid = 1'b1;
        line_rx_sop = sop;
        line_rx_eop = eop;
        line_rx_data = d;
        tick(3);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_plain;
        txq.delete();
        send_frame(3, 1'b0, 16'h1234, 64'h0123_4567_89ab_cde0);
        wait_for(3, 1'b0);
        for (int i = 0; i < 3; i++) chk_word("line data", 64'h0123_4567_89ab_cde0 + 64'(i), txq[i]);
        chk_word("capture idle", 64'(mptc_pkg::CAPTURE_RESET), 64'(tx_capture_value));
        chk_bit("ready idle", 1'b0, capture_ready_flag);
        chk_word("line ends", 64'h1, 64'(eopn));
        $display("test plain done");
    endtask

    task automatic test_capture;
        logic [31:0] v1;
        logic [31:0] v2;
        txq.delete();
        sopq.delete();
        send_frame(1, 1'b1, 16'h8005, 64'h0000_0000_0000_1588);
        wait_for(1, 1'b0);
        v1 = tx_capture_value;
        chk_bit("ready set", 1'b1, capture_ready_flag);
        send_frame(2, 1'b1, 16'h0006, 64'h0000_0000_0000_2000);
        wait_for(3, 1'b0);
        v2 = tx_capture_value - v1;
        chk_word("capture step", 64'((sopq[1] - sopq[0]) * 4), 64'(v2));
        chk_bit("ready polled", 1'b1, capture_ready_flag);
        sw_capture_read = 1'b1;
        tick(1);
        sw_capture_read = 1'b0;
        chk_bit("ready cleared", 1'b0, capture_ready_flag);
        v1 = tx_capture_value;
        send_frame(2, 1'b0, 16'h0007, 64'h0000_0000_0000_3000);
        wait_for(5, 1'b0);
        chk_word("capture kept", 64'(v1), 64'(tx_capture_value));
        chk_bit("ready kept low", 1'b0, capture_ready_flag);
        $display("test capture done");
    endtask

    task automatic test_receive;
        logic [29:0] d;
        rxd.delete();
        line_word(1'b1, 1'b0, 64'hfeed_0000_0000_0001);
        line_word(1'b0, 1'b1, 64'hfeed_0000_0000_0002);
        line_rx_valid = 1'b0;
        line_rx_data = 64'h0112_ffff_ffff_fffd;
        wait_for(2, 1'b1);
        chk_word("rx data 0", 64'hfeed_0000_0000_0001, rxd[0]);
        chk_word("rx data 1", 64'hfeed_0000_0000_0002, rxd[1]);
        chk_bit("rx begin", 1'b1, rxs[0]);
        chk_bit("rx second", 1'b0, rxs[1]);
        chk_bit("rx end", 1'b1, rxe[1]);
        // Each word has its own stamp on the link; fabric keeps the first
        d = lts[1] - lts[0];
        chk_word("rx stamp step", 64'h0c, 64'(d));
        chk_word("rx stamp latched", 64'(lts[0]), 64'(rxt[0]));
        chk_word("rx stamp held", 64'(rxt[0]), 64'(rxt[1]));
        chk_word("rx stamp width", 64'h1e, 64'($bits(u_mptc_link_if.rx_ts)));
        $display("test receive done");
    endtask

    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        srst = 1'b1;
        {usr_tx_valid, usr_tx_sop, usr_tx_eop, usr_tx_event, sw_capture_read} = 5'h00;
        {line_rx_valid, line_rx_sop, line_rx_eop} = 3'h0;
        usr_tx_data = 64'h0;
        usr_tx_tag = 16'h0;
        line_rx_data = 64'h0;
        tick(4);
        srst = 1'b0;
        tick(2);
        chk_word("capture reset", 64'(mptc_pkg::CAPTURE_RESET), 64'(tx_capture_value));
        chk_bit("ready reset", 1'b0, capture_ready_flag);
        test_plain();
        test_capture();
        test_receive();
        stop_test();
    end

    // Tests need well under 2000 cycles
    initial
    begin
        #20000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
